// ===== verilog/ltg_pkg.sv
/*
 ltg_pkg: shared constants and types of the panel timing generator.
 Assumes one system clock; register offsets are byte addresses on AXI4-Lite.
*/
package ltg_pkg;
    // bus and register map
    localparam int AXI_AW = 8;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 4;
    localparam int NREG = 7;
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_PCD = 3'h1;
    localparam logic [2:0] IDX_HSIZE = 3'h2;
    localparam logic [2:0] IDX_HWAIT = 3'h3;
    localparam logic [2:0] IDX_VSIZE = 3'h4;
    localparam logic [2:0] IDX_VWAIT = 3'h5;
    localparam logic [2:0] IDX_SEG = 3'h6;
    localparam logic [2:0] IDX_STAT = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // control register fields
    localparam int C_EN = 0;
    localparam int C_MODE = 1;
    localparam int C_BW = 3;
    localparam int C_PSCLK = 5;
    localparam int C_PDATA = 6;
    localparam int C_PFS = 7;
    localparam int C_PLS = 8;
    localparam int C_POE = 9;
    localparam int C_GATE = 10;
    // timing register fields
    localparam int DIV_W = 8;
    localparam int F8_W = 8;
    localparam int PIXELS_PER_LINE_LSB = 0;
    localparam int PIXELS_PER_LINE_W = 10;
    localparam int HWID_LSB = 16;
    localparam int WID_W = 6;
    localparam int LINES_LSB = 0;
    localparam int VWID_LSB = 16;
    localparam int END_LSB = 0;
    localparam int START_LSB = 8;
    localparam int CRISE_LSB = 0;
    localparam int CHI_LSB = 8;
    localparam int PSR_LSB = 16;
    localparam int REV_LSB = 24;
    // status register fields
    localparam int ST_LINE_LSB = 0;
    localparam int ST_VPH_LSB = 16;
    localparam int ST_HPH_LSB = 20;
    // counters and fixed waits, in shift clocks
    localparam int HC_W = 11;
    localparam int VC_W = 10;
    localparam logic [HC_W-1:0] START_TFT = 11'h3;
    localparam logic [HC_W-1:0] START_SEG = 11'h4;
    localparam logic [HC_W-1:0] START_PAS = 11'h2;
    localparam logic [HC_W-1:0] PCNT_MAX = 11'h7ff;
    localparam int PIX_W = 18;
    localparam logic [1:0] GATE_RUN = 2'h0;
    localparam logic [1:0] GATE_NO_FS = 2'h1;
    localparam logic [1:0] GATE_NO_IDLE = 2'h2;

    typedef enum logic [1:0] {MODE_TFT, MODE_SEG, MODE_CSTN, MODE_MONO} ltg_mode_t;
    typedef enum logic [1:0] {H_SYNC, H_START, H_ACT, H_END} ltg_hph_t;
    typedef enum logic [1:0] {V_SYNC, V_START, V_ACT, V_END} ltg_vph_t;

    typedef struct packed {
        logic sclk;
        logic line_sync;
        logic frame_sync;
        logic data_en;
        logic start_pulse;
        logic gate_clock;
        logic power_save;
        logic invert;
        logic [PIX_W-1:0] pixel_data;
    } ltg_panel_t;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
    } ltg_div_st_t;

    typedef struct packed {
        logic [NREG-1:0][31:0] cfg;
        logic awrdy;
        logic wrdy;
        logic arrdy;
        logic aw_ok;
        logic [AXI_AW-1:0] aw_addr;
        logic w_ok;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        ltg_hph_t hph;
        logic [HC_W-1:0] hcnt;
        ltg_vph_t vph;
        logic [VC_W-1:0] vcnt;
        logic [VC_W-1:0] line;
        logic [HC_W-1:0] pcnt;
        logic pix_req;
        ltg_panel_t panel;
    } ltg_st_t;
endpackage : ltg_pkg

// ===== verilog/ltg_tick_div.sv
/*
 ltg_tick_div: step counter that divides a step strobe by i_div + 1.
 Assumes i_step is a one-cycle strobe in the caller's clock domain.
*/
module ltg_tick_div
    import ltg_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // rate control
    input wire logic i_step,
    input wire logic [DIV_W-1:0] i_div,
    // strobes
    output logic o_tick,
    output logic o_high
);
    ltg_div_st_t s_r;
    ltg_div_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (i_step) begin
            if (s_r.cnt >= i_div) begin
                s_nxt.cnt = '0;
            end else begin
                s_nxt.cnt = s_r.cnt + 8'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_tick = i_step && (s_r.cnt >= i_div);
    // first half of the period high; a divide by one stays high
    assign o_high = s_r.cnt <= (i_div >> 1);
endmodule : ltg_tick_div

// ===== verilog/ltg_timing_gen.sv
/*
 ltg_timing_gen: panel timing generator with AXI4-Lite configuration.
 Assumes an AXI4-Lite master on i_clk_sys and a pixel source that always
 has the next word ready when o_pix_req pulses.
*/
// Behaviour
// - pixel clock is controller clock over divisor+1
// - shift clock equals pixel clock unless wide mono
// - wide mono: shift clock is pixel clock/width
// - shift clock and data polarity selectable
// - tft line period: pixels plus sync, waits
// - tft data end to frame sync gap
// - tft frame sync end to first data
// - tft data starts start wait+3 after sync
// - tft line sync starts end wait+1 after data
// - tft sync and data enable polarity selectable
// - shift clock stops per gating mode or runs
// - start pulse one clock, falls at data
// - segment: line sync end wait+1 after data
// - segment: data start wait+4 after sync
// - gate clock delayed rise, programmed high width
// - power save falls at gate rise, delayed rise
// - inversion toggles once per line after data
// - passive: sync width, waits in shift clocks
// - passive sync and shift clock polarity selectable
// - cstn or 1-bit mono: two pixel clock offset
// - wide mono offset follows bus width
module ltg_timing_gen
    import ltg_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // axi4-lite write channels
    input wire logic [AXI_AW-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read channels
    input wire logic [AXI_AW-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // pixel source
    input wire logic [PIX_W-1:0] i_pix_data,
    output logic o_pix_req,
    // panel pins
    output ltg_panel_t o_panel
);
    logic [1:0] rst_q_r;
    logic rstn_s;
    ltg_st_t s_r;
    ltg_st_t s_nxt;
    logic [31:0] ctrl;
    logic en;
    ltg_mode_t mode;
    logic [1:0] bw;
    logic [1:0] gmode;
    logic seg;
    logic pas;
    logic psclk;
    logic pdata;
    logic [DIV_W-1:0] pixel_clock_divisor;
    logic [DIV_W-1:0] sdiv;
    logic [PIXELS_PER_LINE_W-1:0] pixels_per_line;
    logic [VC_W-1:0] lines;
    logic [WID_W-1:0] hwid;
    logic [WID_W-1:0] vwid;
    logic [F8_W-1:0] hw1;
    logic [F8_W-1:0] hw2;
    logic [F8_W-1:0] vw1;
    logic [F8_W-1:0] vw2;
    logic [F8_W-1:0] crise;
    logic [F8_W-1:0] chi;
    logic [F8_W-1:0] psr;
    logic [F8_W-1:0] rev;
    logic [HC_W-1:0] start_add;
    logic pix_tick;
    logic pix_high;
    logic sh_tick;
    logic sh_high;
    logic wr_fire;
    logic de_int;
    logic fs_int;

    // reset release through two flops
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_q_r <= 2'h0;
        end else begin
            rst_q_r <= {rst_q_r[0], 1'h1};
        end
    end
    assign rstn_s = rst_q_r[1];

    // configuration fields
    assign ctrl = s_r.cfg[IDX_CTRL];
    assign en = ctrl[C_EN];
    assign mode = ltg_mode_t'(ctrl[C_MODE +: 2]);
    assign bw = ctrl[C_BW +: 2];
    assign gmode = ctrl[C_GATE +: 2];
    assign psclk = ctrl[C_PSCLK];
    assign pdata = ctrl[C_PDATA];
    assign seg = mode == MODE_SEG;
    assign pas = (mode == MODE_CSTN) || (mode == MODE_MONO);
    assign pixel_clock_divisor = s_r.cfg[IDX_PCD][DIV_W-1:0];
    assign pixels_per_line = s_r.cfg[IDX_HSIZE][PIXELS_PER_LINE_LSB +: PIXELS_PER_LINE_W];
    assign hwid = s_r.cfg[IDX_HSIZE][HWID_LSB +: WID_W];
    assign hw1 = s_r.cfg[IDX_HWAIT][END_LSB +: F8_W];
    assign hw2 = s_r.cfg[IDX_HWAIT][START_LSB +: F8_W];
    assign lines = s_r.cfg[IDX_VSIZE][LINES_LSB +: VC_W];
    assign vwid = s_r.cfg[IDX_VSIZE][VWID_LSB +: WID_W];
    assign vw1 = s_r.cfg[IDX_VWAIT][END_LSB +: F8_W];
    assign vw2 = s_r.cfg[IDX_VWAIT][START_LSB +: F8_W];
    assign crise = s_r.cfg[IDX_SEG][CRISE_LSB +: F8_W];
    assign chi = s_r.cfg[IDX_SEG][CHI_LSB +: F8_W];
    assign psr = s_r.cfg[IDX_SEG][PSR_LSB +: F8_W];
    assign rev = s_r.cfg[IDX_SEG][REV_LSB +: F8_W];
    assign start_add = seg ? START_SEG : (pas ? START_PAS : START_TFT);

    // wide mono bus divides shift clock by 2, 4 or 8
    assign sdiv = (mode == MODE_MONO) ? 8'((9'h1 << bw) - 9'h1) : 8'h0;

    ltg_tick_div u_pix_div (
        .i_clk(i_clk_sys),
        .i_rstn(rstn_s),
        .i_step(en),
        .i_div(pixel_clock_divisor),
        .o_tick(pix_tick),
        .o_high(pix_high)
    );

    ltg_tick_div u_shift_div (
        .i_clk(i_clk_sys),
        .i_rstn(rstn_s),
        .i_step(pix_tick),
        .i_div(sdiv),
        .o_tick(sh_tick),
        .o_high(sh_high)
    );

    assign wr_fire = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
    assign de_int = (s_r.hph == H_ACT) && (s_r.vph == V_ACT);
    assign fs_int = s_r.vph == V_SYNC;

    // horizontal phase lengths, minus one
    function automatic logic [HC_W-1:0] hload(input ltg_hph_t ph);
        logic [HC_W-1:0] v;
        case (ph)
            H_SYNC: v = HC_W'(hwid);
            H_START: v = HC_W'(hw2) + start_add - 11'h1;
            H_ACT: v = HC_W'(pixels_per_line) - 11'h1;
            default: v = HC_W'(hw1);
        endcase
        return v;
    endfunction : hload

    // vertical phase lengths in lines, minus one
    function automatic logic [VC_W-1:0] vload(input ltg_vph_t ph);
        logic [VC_W-1:0] v;
        case (ph)
            V_SYNC: v = VC_W'(vwid) - 10'h1;
            V_START: v = VC_W'(vw2) - 10'h1;
            V_ACT: v = lines - 10'h1;
            default: v = VC_W'(vw1) - 10'h1;
        endcase
        return v;
    endfunction : vload

    // empty waits are skipped
    function automatic ltg_vph_t vnext(input ltg_vph_t ph);
        ltg_vph_t v;
        case (ph)
            V_SYNC: v = (vw2 == 8'h0) ? V_ACT : V_START;
            V_START: v = V_ACT;
            V_ACT: v = (vw1 == 8'h0) ? V_SYNC : V_END;
            default: v = V_SYNC;
        endcase
        return v;
    endfunction : vnext

    always_comb begin
        logic [AXI_AW-1:0] ra;
        logic [2:0] widx;
        logic [2:0] ridx;
        logic [31:0] rv;
        logic last_data;
        logic run;
        logic lvl;
        logic [HC_W-1:0] g_on;
        logic [HC_W-1:0] g_off;
        logic [HC_W-1:0] p_off;
        ltg_hph_t hn;
        ltg_vph_t vn;
        ra = i_araddr;
        widx = s_r.aw_addr[IDX_MSB:IDX_LSB];
        ridx = ra[IDX_MSB:IDX_LSB];
        rv = '0;
        last_data = 1'h0;
        run = 1'h0;
        lvl = 1'h0;
        g_on = HC_W'(crise) + 11'h1;
        g_off = g_on + HC_W'(chi) + 11'h1;
        p_off = g_off + HC_W'(psr);
        hn = H_SYNC;
        vn = V_SYNC;
        s_nxt = s_r;
        s_nxt.pix_req = 1'h0;

        // write address and data in either order
        if (i_awvalid && s_r.awrdy) begin
            s_nxt.aw_ok = 1'h1;
            s_nxt.aw_addr = i_awaddr;
        end
        if (i_wvalid && s_r.wrdy) begin
            s_nxt.w_ok = 1'h1;
            s_nxt.wd = i_wdata;
            s_nxt.ws = i_wstrb;
        end
        if (wr_fire) begin
            s_nxt.aw_ok = 1'h0;
            s_nxt.w_ok = 1'h0;
            s_nxt.bvalid = 1'h1;
            s_nxt.bresp = RESP_OKAY;
            if (s_r.aw_addr[AXI_AW-1:IDX_MSB+1] != '0) begin
                s_nxt.bresp = RESP_SLVERR;
            end else if (widx != IDX_STAT) begin
                for (int b = 0; b < 4; b++) begin
                    if (s_r.ws[b]) begin
                        s_nxt.cfg[widx][b*8 +: 8] = s_r.wd[b*8 +: 8];
                    end
                end
            end
        end
        if (s_r.bvalid && i_bready) begin
            s_nxt.bvalid = 1'h0;
        end
        s_nxt.awrdy = !s_nxt.aw_ok;
        s_nxt.wrdy = !s_nxt.w_ok;

        // read channel, one read outstanding
        if (i_arvalid && s_r.arrdy) begin
            if (ridx == IDX_STAT) begin
                rv[ST_LINE_LSB +: VC_W] = s_r.line;
                rv[ST_VPH_LSB +: 2] = s_r.vph;
                rv[ST_HPH_LSB +: 2] = s_r.hph;
            end else begin
                rv = s_r.cfg[ridx];
            end
            s_nxt.rvalid = 1'h1;
            s_nxt.rresp = RESP_OKAY;
            s_nxt.rdata = rv;
            if (ra[AXI_AW-1:IDX_MSB+1] != '0) begin
                s_nxt.rresp = RESP_SLVERR;
                s_nxt.rdata = '0;
            end
        end else if (s_r.rvalid && i_rready) begin
            s_nxt.rvalid = 1'h0;
        end
        s_nxt.arrdy = !s_nxt.rvalid;

        // line and frame sequencing on shift clock ticks
        if (!en) begin
            s_nxt.hph = H_SYNC;
            s_nxt.hcnt = hload(H_SYNC);
            s_nxt.vph = V_SYNC;
            s_nxt.vcnt = vload(V_SYNC);
            s_nxt.line = '0;
            s_nxt.pcnt = PCNT_MAX;
        end else if (sh_tick) begin
            last_data = de_int && (s_r.hcnt == '0);
            if (s_r.hcnt != '0) begin
                s_nxt.hcnt = s_r.hcnt - 11'h1;
            end else begin
                hn = ltg_hph_t'(s_r.hph + 2'h1);
                s_nxt.hph = hn;
                s_nxt.hcnt = hload(hn);
                if (s_r.hph == H_END) begin
                    if (s_r.vcnt != '0) begin
                        s_nxt.vcnt = s_r.vcnt - 10'h1;
                    end else begin
                        vn = vnext(s_r.vph);
                        s_nxt.vph = vn;
                        s_nxt.vcnt = vload(vn);
                    end
                    s_nxt.line = (s_r.vph == V_ACT) ? s_r.line + 10'h1 : '0;
                end
            end
            // shift clocks since last data word of a line
            if (last_data) begin
                s_nxt.pcnt = '0;
            end else if (s_r.pcnt != PCNT_MAX) begin
                s_nxt.pcnt = s_r.pcnt + 11'h1;
            end
            s_nxt.panel.start_pulse = seg && (s_nxt.vph == V_ACT) &&
                (s_nxt.hph == H_START) && (s_nxt.hcnt == '0);
            s_nxt.panel.gate_clock = seg && (s_nxt.pcnt >= g_on) &&
                (s_nxt.pcnt < g_off);
            s_nxt.panel.power_save = !(seg && (s_nxt.pcnt >= g_on) &&
                (s_nxt.pcnt < p_off));
            if (seg && (s_nxt.pcnt == HC_W'(rev) + 11'h1)) begin
                s_nxt.panel.invert = !s_r.panel.invert;
            end
            if ((s_nxt.hph == H_ACT) && (s_nxt.vph == V_ACT)) begin
                s_nxt.pix_req = 1'h1;
                s_nxt.panel.pixel_data = i_pix_data ^ {PIX_W{pdata}};
            end
        end
        if (!en || !seg) begin
            s_nxt.panel.start_pulse = 1'h0;
            s_nxt.panel.gate_clock = 1'h0;
            s_nxt.panel.power_save = 1'h1;
        end

        // sync strobes follow the sequencer every cycle
        s_nxt.panel.line_sync = (en && (s_nxt.hph == H_SYNC)) ^ ctrl[C_PLS];
        s_nxt.panel.frame_sync = (en && (s_nxt.vph == V_SYNC)) ^ ctrl[C_PFS];
        s_nxt.panel.data_en = (en && (s_nxt.hph == H_ACT) &&
            (s_nxt.vph == V_ACT)) ^ ctrl[C_POE];
        if (!s_nxt.pix_req && !de_int) begin
            s_nxt.panel.pixel_data = {PIX_W{pdata}};
        end

        // shift clock level, gated as configured
        lvl = (sdiv == 8'h0) ? pix_high : sh_high;
        run = en && !((gmode == GATE_NO_FS) && fs_int) &&
            !((gmode == GATE_NO_IDLE) && !de_int);
        s_nxt.panel.sclk = (run && lvl) ^ psclk;
    end

    always_ff @(posedge i_clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_awready = s_r.awrdy;
    assign o_wready = s_r.wrdy;
    assign o_bvalid = s_r.bvalid;
    assign o_bresp = s_r.bresp;
    assign o_arready = s_r.arrdy;
    assign o_rvalid = s_r.rvalid;
    assign o_rdata = s_r.rdata;
    assign o_rresp = s_r.rresp;
    assign o_pix_req = s_r.pix_req;
    assign o_panel = s_r.panel;

    // line period measured between line sync starts
    logic [11:0] lp_cnt_r;
    logic lp_ok_r;
    logic [11:0] lp_exp;
    assign lp_exp = 12'(pixels_per_line) + 12'(hwid) + 12'(hw2) + 12'(start_add) + 12'(hw1) + 12'h1;

    always_ff @(posedge i_clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            lp_cnt_r <= '0;
            lp_ok_r <= 1'h0;
        end else if (!en || wr_fire) begin
            lp_cnt_r <= '0;
            lp_ok_r <= 1'h0;
        end else if (sh_tick) begin
            if ((s_r.hph == H_END) && (s_r.hcnt == '0)) begin
                lp_cnt_r <= '0;
                lp_ok_r <= 1'h1;
            end else begin
                lp_cnt_r <= lp_cnt_r + 12'h1;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!rstn_s || wr_fire);

    sequence s_three_gap;
        !pix_tick ##1 !pix_tick ##1 pix_tick;
    endsequence

    // 2-bit mono at divisor 2: six cycles per shift tick
    sequence s_six_gap;
        !sh_tick [*5] ##1 sh_tick;
    endsequence

    a_pix_divide: assert property ((en && pix_tick && pixel_clock_divisor == 8'h2) |=> s_three_gap)
        else $error("pixel tick period wrong");
    a_shift_equal: assert property ((en && sdiv == 8'h0) |-> (sh_tick == pix_tick))
        else $error("shift tick differs from pixel tick");
    a_shift_half: assert property ((sh_tick && sdiv == 8'h1 && pixel_clock_divisor == 8'h2) |=> s_six_gap)
        else $error("wide mono shift rate wrong");
    a_data_pol: assert property (o_pix_req |-> (o_panel.pixel_data == ($past(i_pix_data) ^ {PIX_W{$past(pdata)}})))
        else $error("pixel data polarity wrong");
    a_line_period: assert property ((sh_tick && lp_ok_r && s_r.hph == H_END &&
        s_r.hcnt == '0) |-> (lp_cnt_r == lp_exp))
        else $error("line period length wrong");
    a_sclk_stop: assert property ((en && gmode == GATE_NO_FS && fs_int) |=> (o_panel.sclk == $past(psclk)))
        else $error("shift clock not stopped in frame sync");
    a_start_fall: assert property ((en && $fell(o_panel.start_pulse)) |-> o_pix_req)
        else $error("start pulse not aligned with first word");
    a_ps_at_gate: assert property ($rose(o_panel.gate_clock) |-> !o_panel.power_save)
        else $error("power save high at gate rise");
    a_inv_on_tick: assert property ($changed(o_panel.invert) |-> ($past(sh_tick) && $past(seg)))
        else $error("inversion moved off a shift tick");
endmodule : ltg_timing_gen

// ===== tb/ltg_panel_model.sv
/*
 ltg_panel_model: panel side, measures line timing in system clocks.
 Assumes panel pins registered in the system clock domain.
*/
module ltg_panel_model
    import ltg_pkg::*;
(
    // clock and pins
    input wire logic i_clk_sys,
    input wire ltg_panel_t i_panel,
    input wire logic i_pol_ls,
    input wire logic i_pol_de,
    // measurements
    output int o_period,
    output int o_ls_w,
    output int o_gap,
    output int o_de_w,
    output int o_lines,
    output int o_tail,
    output int o_gate_d,
    output int o_gate_w,
    output int o_ps_d,
    output int o_inv,
    output int o_sck
);
    timeunit 1ns;
    timeprecision 100ps;
    int t = 0;
    int t_ls = 0;
    int t_lf = 0;
    int t_de = 0;
    int t_df = 0;
    int t_gr = 0;
    int t_gf = 0;
    logic ls_q = 1'b0;
    logic de_q = 1'b0;
    logic gc_q = 1'b0;
    logic ps_q = 1'b0;
    logic inv_q = 1'b0;
    logic sck_q = 1'b0;
    logic ls;
    logic de;
    always @(posedge i_clk_sys) begin
        t = t + 1;
        ls = i_panel.line_sync ^ i_pol_ls;
        de = i_panel.data_en ^ i_pol_de;
        if (ls && !ls_q) begin
            o_period <= t - t_ls;
            o_lines <= o_lines + 1;
            o_tail <= t - t_df;
            t_ls = t;
        end
        if (!ls && ls_q) begin
            o_ls_w <= t - t_ls;
            t_lf = t;
        end
        if (de && !de_q) begin
            o_gap <= t - t_lf;
            t_de = t;
        end
        if (!de && de_q) begin
            o_de_w <= t - t_de;
            t_df = t;
        end
        // segment strobes carry no polarity bit
        if (i_panel.gate_clock && !gc_q) begin
            o_gate_d <= t - t_df;
            t_gr = t;
        end
        if (!i_panel.gate_clock && gc_q) begin
            o_gate_w <= t - t_gr;
            t_gf = t;
        end
        if (i_panel.power_save && !ps_q) o_ps_d <= t - t_gf;
        if (i_panel.invert != inv_q) o_inv <= o_inv + 1;
        if (i_panel.sclk != sck_q) o_sck <= o_sck + 1;
        ls_q = ls;
        de_q = de;
        gc_q = i_panel.gate_clock;
        ps_q = i_panel.power_save;
        inv_q = i_panel.invert;
        sck_q = i_panel.sclk;
    end
endmodule : ltg_panel_model

// ===== tb/testbench.sv
/*
 testbench: random line timing configurations over AXI4-Lite, checked
 against the panel model. Assumes the 40 MHz system clock only.
*/
module testbench
    import ltg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, pol_ls, pol_de;
    logic awready, wready, bvalid, arready, rvalid, pix_req;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [PIX_W-1:0] pix;
    ltg_panel_t panel;
    int fail_count, checked, seed, npix, period, ls_w, gap, de_w, lines;
    int tail, gd, gw, psd, inv, sck;

    ltg_timing_gen u_ltg_timing_gen(.i_clk_sys(clk), .i_rstn(rstn), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_pix_data(pix), .o_pix_req(pix_req), .o_panel(panel));
    ltg_panel_model u_ltg_panel_model(.i_clk_sys(clk), .i_panel(panel), .i_pol_ls(pol_ls),
        .i_pol_de(pol_de), .o_period(period), .o_ls_w(ls_w), .o_gap(gap), .o_de_w(de_w),
        .o_lines(lines), .o_tail(tail), .o_gate_d(gd), .o_gate_w(gw), .o_ps_d(psd),
        .o_inv(inv), .o_sck(sck));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        pix <= PIX_W'($random(seed));
        if (pix_req === 1'b1) npix = npix + 1;
    end

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        r = 2'h3;
        while (r === 2'h3) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) r = bresp;
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                done = 1'b1;
            end
        end
        rready <= 1'b0;
    endtask : rd

    task automatic wait_lines(input int n);
        int l0;
        l0 = lines;
        while (lines < l0 + n) @(posedge clk);
    endtask : wait_lines

    function automatic int exp_start(input int mode);
        return (mode == 0) ? 3 : (mode == 1) ? 4 : 2;
    endfunction : exp_start

    function automatic int exp_div(input int mode, input int bw, input int pixel_clock_divisor);
        return (pixel_clock_divisor + 1) * ((mode == 3) ? (1 << bw) : 1);
    endfunction : exp_div

    task automatic complete_run();
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (80000) @(posedge clk);
        fail_count++;
        complete_run();
    end

    initial begin
        logic [31:0] ctrl, rv;
        logic [1:0] resp;
        int mode, bw, pixel_clock_divisor, xm, hwd, h1, h2, dv, st, p0, i0, s0, ln;
        {rstn, awvalid, wvalid, bready, arvalid, rready, pol_ls, pol_de} = 8'h00;
        {awaddr, araddr, wdata, wstrb, pix} = '0;
        seed = 32'ha287;
        fail_count = 0;
        checked = 0;
        npix = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h20, rv, resp);
        check("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        check("unmapped rdata", rv, 32'h0);
        wr(8'h20, 32'hffffffff, resp);
        check("unmapped bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        for (int it = 0; it < 8; it++) begin
            // corner at it 3: 2-bit mono at the smallest legal divisor
            mode = it % 4;
            bw = (it == 3) ? 1 : $random(seed) & 3;
            pixel_clock_divisor = (it == 3) ? 2 : 2 + ($random(seed) & 3);
            xm = 1 + ($random(seed) & 7);
            hwd = $random(seed) & 3;
            h1 = $random(seed) & 3;
            h2 = $random(seed) & 3;
            ctrl = {20'h0, 2'(it % 3), 5'($random(seed)), 2'(bw), 2'(mode), 1'b0};
            wr(8'h00, ctrl, resp);
            wr(8'h04, 32'(pixel_clock_divisor), resp);
            rd(8'h04, rv, resp);
            check("divisor readback", {24'h0, rv[7:0]}, 32'(pixel_clock_divisor));
            wr(8'h08, 32'(xm) | (32'(hwd) << HWID_LSB), resp);
            wr(8'h0c, 32'(h1) | (32'(h2) << START_LSB), resp);
            wr(8'h10, 32'h3ff | (32'h1 << VWID_LSB), resp);
            wr(8'h14, 32'h0, resp);
            // gate rise 1, gate high 1, save rise 1, invert delay 1
            wr(8'h18, 32'h01010101, resp);
            check("write bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
            pol_ls <= ctrl[C_PLS];
            pol_de <= ctrl[C_POE];
            wr(8'h00, ctrl | 32'h1, resp);
            wait_lines(4);
            p0 = npix;
            i0 = inv;
            s0 = sck;
            wait_lines(2);
            dv = exp_div(mode, bw, pixel_clock_divisor);
            st = exp_start(mode);
            ln = hwd + 1 + h2 + st + xm + h1 + 1;
            check("line period", period, ln * dv);
            check("sync width", ls_w, (hwd + 1) * dv);
            check("end wait", tail, (h1 + 1) * dv);
            check("pixel words", npix - p0, 2 * xm);
            if (ctrl[C_GATE +: 2] == GATE_RUN) begin
                check("sclk edges", sck - s0, 4 * ln);
            end
            if (mode < 2) begin
                check("sync to enable", gap, (h2 + st) * dv);
                check("enable width", de_w, xm * dv);
            end
            if (mode == 1) begin
                check("gate delay", gd, 2 * dv);
                check("gate width", gw, 2 * dv);
                check("save delay", psd, dv);
                check("inversions", inv - i0, 2);
            end
        end
        complete_run();
    end
endmodule : testbench
